// [hdl/rcos_pkg.sv]
package rcos_pkg;

	// Register map, byte addresses on the APB bus
	localparam logic [11:0] ADDR_CONFIG        = 12'h000;
	localparam logic [11:0] ADDR_SOURCE        = 12'h004;
	localparam logic [11:0] ADDR_STATUS        = 12'h008;

	// Configuration register fields
	localparam int          FREQ_LSB           = 0;
	localparam int          FREQ_MSB           = 2;
	localparam int          FREE_BIT           = 3;
	localparam int          BYPASS_BIT         = 4;
	localparam int          HOLD_BIT           = 5;
	localparam logic [7:0]  CONFIG_RESET       = 8'h00;
	localparam logic [7:0]  CONFIG_MASK        = 8'h3f;

	// Source register fields
	localparam int          SRC_EXT_BIT        = 0;
	localparam int          SRC_E1_BIT         = 1;
	localparam logic [7:0]  SOURCE_RESET       = 8'h00;
	localparam logic [7:0]  SOURCE_MASK        = 8'h03;

	// Frequency codes
	localparam logic [2:0]  FREQ_SOURCE        = 3'h0;
	localparam logic [2:0]  FREQ_RESERVED      = 3'h3;

	// Output selection encodings reported in status
	localparam logic [2:0]  SEL_LOCKED         = 3'h1;
	localparam logic [2:0]  SEL_FREE           = 3'h2;
	localparam logic [2:0]  SEL_HIGH           = 3'h4;

	// Rates, in kHz, and the system clock rate
	localparam int          CLK_KHZ            = 250000;
	localparam int          T1_KHZ             = 1544;
	localparam int          E1_KHZ             = 2048;

	// Output rates for each master-clock-derived setting, Hz figures
	localparam int          RATE_8K_HZ         = 8000;
	localparam int          RATE_64K_HZ        = 64000;
	localparam int          RATE_4M_HZ         = 4096000;
	localparam int          RATE_8M_HZ         = 8192000;
	localparam int          RATE_19M_HZ        = 19440000;
	localparam int          RATE_32M_HZ        = 32768000;
	localparam int          RATE_T1_HZ         = T1_KHZ * 1000;
	localparam int          RATE_E1_HZ         = E1_KHZ * 1000;
	localparam int          CLK_HZ             = CLK_KHZ * 1000;

	// Half period in clock cycles, rounded down, at least one
	function automatic logic [15:0] rcos_half(input int hz);
		int c;
		c = CLK_HZ / (2 * hz);
		if (c < 1) begin
			c = 1;
		end
		return c[15:0];
	endfunction

	typedef enum logic [2:0] {
		RCOS_LOCKED = 3'b001,
		RCOS_FREE   = 3'b010,
		RCOS_HIGH   = 3'b100
	} rcos_mode_type;

endpackage

// [hdl/rcos_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module rcos_sync
	import rcos_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_r;

	// Width must hold at least one bit
	if (WIDTH < 1) begin : g_width_check
		$error("rcos_sync: WIDTH below one");
	end

	// Two-stage synchroniser, first stage read only by second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule

`default_nettype wire

// [hdl/rcos_divider.sv]
`timescale 1ns/100ps
`default_nettype none

module rcos_divider
	import rcos_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] half_count,
	output logic             clk_out
);

	logic [15:0] count_r;

	// Toggle output every half_count cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= 16'h0000;
			clk_out <= 1'b0;
		end else if (count_r + 16'h0001 >= half_count) begin
			count_r <= 16'h0000;
			clk_out <= ~clk_out;
		end else begin
			count_r <= count_r + 16'h0001;
		end
	end

endmodule

`default_nettype wire

// [hdl/rcos_ref_out.sv]
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rcos_ref_out
	import rcos_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_clock_in_a,
	input  wire logic        recovered_line_clock,
	input  wire logic        source_lost,
	output logic             reference_output_a
);

	////////////////////////////////////////////////////////////////////
	// Registers and synchronised inputs

	logic [7:0]     reference_output_config_r;
	logic [7:0]     source_config_r;
	rcos_mode_type  mode_r;
	rcos_mode_type  mode_nxt;
	logic [15:0]    half_r;
	logic [15:0]    half_nxt;
	logic           lost_s;
	logic           ext_s;
	logic           line_s;
	logic           free_clk;
	logic           src_clk;
	logic           undefined_r;
	logic           undefined_nxt;

	logic           synth_bypass;
	logic           synth_free_run;
	logic           loss_hold_high;
	logic [2:0]     synth_freq_select;
	logic           src_is_ext;
	logic           src_is_e1;

	assign synth_freq_select = reference_output_config_r[FREQ_MSB:FREQ_LSB];
	assign synth_free_run    = reference_output_config_r[FREE_BIT];
	assign synth_bypass      = reference_output_config_r[BYPASS_BIT];
	assign loss_hold_high    = reference_output_config_r[HOLD_BIT];
	assign src_is_ext        = source_config_r[SRC_EXT_BIT];
	assign src_is_e1         = source_config_r[SRC_E1_BIT];

	// Pins pass two flops before use
	rcos_sync #(
		.WIDTH (3)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({source_lost, external_clock_in_a, recovered_line_clock}),
		.dout    ({lost_s, ext_s, line_s})
	);

	// Selected source clock
	assign src_clk = src_is_ext ? ext_s : line_s;

	////////////////////////////////////////////////////////////////////
	// Frequency decode

	// Half period for a frequency code, or the line rate
	function automatic logic [15:0] rcos_code_half(
		input logic [2:0] code,
		input logic       e1
	);
		logic [15:0] h;
		h = e1 ? rcos_half(RATE_E1_HZ) : rcos_half(RATE_T1_HZ);
		case (code)
			3'h1:    h = rcos_half(RATE_8K_HZ);
			3'h2:    h = rcos_half(RATE_64K_HZ);
			3'h4:    h = rcos_half(RATE_4M_HZ);
			3'h5:    h = rcos_half(RATE_8M_HZ);
			3'h6:    h = rcos_half(RATE_19M_HZ);
			3'h7:    h = rcos_half(RATE_32M_HZ);
			default: h = h;
		endcase
		return h;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Output mode selection

	always_comb begin
		mode_nxt      = RCOS_LOCKED;
		half_nxt      = rcos_code_half(synth_freq_select, src_is_e1);
		undefined_nxt = 1'b0;
		if (!lost_s) begin
			if (synth_bypass) begin
				mode_nxt = RCOS_LOCKED;
			end else if (synth_free_run) begin
				mode_nxt = RCOS_FREE;
				if (synth_freq_select == FREQ_SOURCE) begin
					undefined_nxt = 1'b1;
				end
			end else begin
				mode_nxt = RCOS_LOCKED;
			end
		end else if (src_is_ext) begin
			if (!synth_bypass && synth_free_run) begin
				mode_nxt = RCOS_FREE;
			end else begin
				mode_nxt = RCOS_HIGH;
			end
		end else if (!synth_bypass) begin
			if (synth_free_run || !loss_hold_high) begin
				mode_nxt = RCOS_FREE;
			end else begin
				mode_nxt = RCOS_HIGH;
			end
		end else begin
			half_nxt = src_is_e1 ? rcos_half(RATE_E1_HZ)
				: rcos_half(RATE_T1_HZ);
			if (loss_hold_high) begin
				mode_nxt = RCOS_HIGH;
			end else begin
				mode_nxt = RCOS_FREE;
			end
		end
		if (synth_bypass && !(lost_s && !src_is_ext)) begin
			half_nxt = src_is_e1 ? rcos_half(RATE_E1_HZ)
				: rcos_half(RATE_T1_HZ);
		end
	end

	// Mode and divider setting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r      <= RCOS_LOCKED;
			half_r      <= 16'h0001;
			undefined_r <= 1'b0;
		end else begin
			mode_r      <= mode_nxt;
			half_r      <= half_nxt;
			undefined_r <= undefined_nxt;
		end
	end

	rcos_divider u_div (
		.pclk       (pclk),
		.presetn    (presetn),
		.half_count (half_r),
		.clk_out    (free_clk)
	);

	// Output mux, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_output_a <= 1'b1;
		end else begin
			case (mode_r)
				RCOS_LOCKED: reference_output_a <= src_clk;
				RCOS_FREE:   reference_output_a <= free_clk;
				RCOS_HIGH:   reference_output_a <= 1'b1;
				default:     reference_output_a <= 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states

	logic access;
	logic bad_addr;
	assign access   = psel && penable;
	assign bad_addr = (paddr != ADDR_CONFIG) && (paddr != ADDR_SOURCE)
		&& (paddr != ADDR_STATUS);

	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_output_config_r <= CONFIG_RESET;
			source_config_r           <= SOURCE_RESET;
		end else if (access && pwrite) begin
			if (paddr == ADDR_CONFIG) begin
				reference_output_config_r <= pwdata[7:0] & CONFIG_MASK;
			end else if (paddr == ADDR_SOURCE) begin
				source_config_r <= pwdata[7:0] & SOURCE_MASK;
			end
		end
	end

	// Read data registered in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			if (paddr == ADDR_CONFIG) begin
				prdata <= {24'h000000, reference_output_config_r};
			end else if (paddr == ADDR_SOURCE) begin
				prdata <= {24'h000000, source_config_r};
			end else if (paddr == ADDR_STATUS) begin
				prdata <= {27'h0000000, undefined_r, lost_s, mode_r};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	// Ready and error, valid in access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && bad_addr;
		end
	end

endmodule

`default_nettype wire

// [test/rcos_ref_out_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module rcos_ref_out_asserts
	import rcos_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        source_lost,
	input wire logic        reference_output_a
);
	logic [5:0] cfg_r;
	logic [1:0] src_r;
	logic [3:0] calm_r;
	logic       lost_r;
	logic       mapped;
	logic       hold_hi;
	logic       calm;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// Shadow of the settings written on the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= 6'h00;
			src_r <= 2'h0;
		end else if (psel && penable && pwrite && pready) begin
			if (paddr == ADDR_CONFIG) cfg_r <= pwdata[5:0];
			if (paddr == ADDR_SOURCE) src_r <= pwdata[1:0];
		end
	end
	// Cycles since the last write or loss change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calm_r <= 4'h0;
			lost_r <= 1'b0;
		end else begin
			lost_r <= source_lost;
			if ((psel && pwrite) || lost_r != source_lost) calm_r <= 4'h0;
			else if (!calm) calm_r <= calm_r + 4'h1;
		end
	end
	// Decode helpers
	assign calm = calm_r == 4'hf;
	assign mapped = paddr == ADDR_CONFIG || paddr == ADDR_SOURCE
		|| paddr == ADDR_STATUS;
	assign hold_hi = src_r[0] ? cfg_r[4] || !cfg_r[3]
		: cfg_r[5] && (cfg_r[4] || !cfg_r[3]);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence done_s;
		psel && penable && pready;
	endsequence
	////////////////////////////////////////
	apb_answer_a: assert property (setup_s |=> done_s)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	error_pair_a: assert property (pslverr |-> pready && !mapped)
		else $error("stray error");
	unmapped_err_a: assert property (setup_s ##0 !mapped |=> pslverr)
		else $error("unmapped without error");
	upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 0)
		else $error("upper read bits set");
	read_back_a: assert property (
		pready && !pwrite && paddr == ADDR_CONFIG |-> prdata == {26'h0, cfg_r})
		else $error("config readback wrong");
	loss_high_a: assert property (
		calm && source_lost && hold_hi |-> reference_output_a)
		else $error("output not high");
	loss_runs_a: assert property (
		calm && source_lost && !hold_hi && (cfg_r[2] || cfg_r[4])
		|-> ##[1:100] ($changed(reference_output_a) || !calm))
		else $error("output not running");
	free_runs_a: assert property (
		calm && !source_lost && cfg_r[3] && !cfg_r[4] && cfg_r[2]
		|-> ##[1:40] ($changed(reference_output_a) || !calm))
		else $error("free clock not running");
endmodule
bind rcos_ref_out rcos_ref_out_asserts chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.source_lost, .reference_output_a);
`default_nettype wire

// [test/rcos_clk_meter.sv]
`timescale 1ns/100ps
`default_nettype none
module rcos_clk_meter (
	input  wire logic        pclk,
	input  wire logic        clk_in,
	input  wire logic        go,
	input  wire logic [15:0] span,
	output var logic         done,
	output var logic  [15:0] val
);
	logic [15:0] left;
	logic [15:0] since;
	logic        seen;
	logic        got;
	logic        prev;
	// Idle until asked to measure
	initial begin
		done = 1'b0;
		left = 16'h0000;
	end
	// Period between rising edges, or the level when static
	always @(posedge pclk) begin
		prev <= clk_in;
		since <= since + 16'h0001;
		done <= left == 16'h0001;
		if (go) begin
			left <= span;
			seen <= 1'b0;
			got <= 1'b0;
		end else if (left != 16'h0000) begin
			left <= left - 16'h0001;
			if (clk_in && !prev) begin
				since <= 16'h0001;
				seen <= 1'b1;
				got <= seen;
				if (seen) val <= since;
			end
			if (left == 16'h0001 && !got) val <= {16{clk_in}};
		end
	end
endmodule
`default_nettype wire

// [test/ref_clock_output_synth_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module ref_clock_output_synth_control_bench
	import rcos_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        external_clock_in_a, recovered_line_clock, source_lost;
	logic        reference_output_a, m_go, m_done;
	logic [15:0] m_span, m_val, lfsr, tick;
	logic [32:0] expq[$];
	int          n_fail, n_compared;
	// Period, lost, source, config per case; ffff means held high
	logic [31:0] tab[18] = '{
		32'h0020_0040, 32'h0040_0000, 32'h0020_0050, 32'h0020_0057,
		32'h0020_0058, 32'hffff_0140, 32'h003c_014c, 32'hffff_015c,
		32'h003c_016c, 32'h003c_0104, 32'hffff_0124, 32'h001e_012d,
		32'h00a0_0110, 32'h007a_0190, 32'hffff_0130, 32'h000c_004e,
		32'h0006_004f, 32'h0f42_004a};
	rcos_ref_out uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .external_clock_in_a,
		.recovered_line_clock, .source_lost, .reference_output_a);
	rcos_clk_meter meter (.pclk, .clk_in(reference_output_a), .go(m_go),
		.span(m_span), .done(m_done), .val(m_val));
	////////////////////////////////////////
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (expq.size() != 0) n_fail++;
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic meas(input logic [31:0] e);
		apb(1'b1, ADDR_CONFIG, {26'h0, e[5:0]});
		apb(1'b1, ADDR_SOURCE, {30'h0, e[7:6]});
		source_lost <= e[8];
		m_span <= &e[31:16] ? 16'h00c8 : 16'h0003 * e[31:16] + 16'h0028;
		repeat (16) @(posedge pclk);
		expq.push_back({17'h0, e[31:16]});
		m_go <= 1'b1;
		@(posedge pclk);
		m_go <= 1'b0;
		do begin
			@(posedge pclk);
		end while (m_done !== 1'b1);
	endtask
	////////////////////////////////////////
	// Clock, source clocks and watchdog
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		tick <= tick + 16'h0001;
		external_clock_in_a <= tick[4];
		recovered_line_clock <= tick[5];
	end
	initial begin
		repeat (40000) @(posedge pclk);
		n_fail++;
		report_and_stop;
	end
	// Results against the oldest note
	always @(posedge pclk) begin
		if ((pready === 1'b1 && !pwrite) || m_done === 1'b1) begin
			check(m_done ? {17'h0, m_val} : {pslverr, prdata},
				expq.size() ? expq.pop_front() : {33{1'bx}});
		end
	end
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, m_go, source_lost} = 6'h00;
		{external_clock_in_a, recovered_line_clock} = 2'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		m_span = 16'h0000;
		tick = 16'h0000;
		lfsr = 16'd45004;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ADDR_CONFIG, {25'h0, CONFIG_RESET});
		rd(ADDR_SOURCE, {25'h0, SOURCE_RESET});
		rd(ADDR_STATUS, {30'h0, SEL_LOCKED});
		rd(12'h00c, {1'b1, 32'h0});
		apb(1'b1, 12'h00c, 32'hffff_ffff);
		apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
		rd(ADDR_CONFIG, {25'h0, CONFIG_RESET});
		repeat (4) begin
			lfsr = next_rand(lfsr);
			apb(1'b1, ADDR_CONFIG, {lfsr, lfsr});
			rd(ADDR_CONFIG, {25'h0, lfsr[7:0] & CONFIG_MASK});
		end
		foreach (tab[i]) meas(tab[i]);
		// Status: mode, loss flag and undefined free-run code
		rd(ADDR_STATUS, {30'h0, SEL_FREE});
		apb(1'b1, ADDR_CONFIG, 32'h0000_0001 << FREE_BIT);
		rd(ADDR_STATUS, {28'h0, 2'b10, SEL_FREE});
		source_lost <= 1'b1;
		apb(1'b1, ADDR_CONFIG, 32'h0000_0001 << BYPASS_BIT);
		rd(ADDR_STATUS, {28'h0, 2'b01, SEL_HIGH});
		report_and_stop;
	end
endmodule
`default_nettype wire
